// ---- rtl/i2c_switch_pkg.sv ----
// shared constants and types of the switch control link
package i2c_switch_pkg;
   localparam int NUM_CHAN = 4;
   localparam int CLK_MHZ = 250;
   localparam int SCL_KHZ = 400;
   localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
   // arbitrary fixed upper address bits
   localparam logic [4:0] ADDR_FIXED_DEFAULT = 5'h0a;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [3:0] IRQ_PINS_IDLE = 4'hf;
   localparam int CHAN_LSB = 0;
   localparam int IRQ_LSB = 4;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b11,
      PH_IGNORE = 2'b10
   } dev_phase_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_START = 2'b01,
      HS_BIT = 2'b11,
      HS_STOP = 2'b10
   } host_state_t;
endpackage

// ---- rtl/i2c_link_if.sv ----
// two-wire link between the bus master end and the switch end
`timescale 1ns/1ns
interface i2c_link_if;
   logic scl;
   logic sda_host_oe;
   logic sda_dev_oe;
   logic sda;
   // open drain with pull-up: low while any end drives
   assign sda = !(sda_host_oe || sda_dev_oe);
   modport dev (input scl, input sda, output sda_dev_oe);
   modport host (output scl, output sda_host_oe, input sda);
endinterface

// ---- rtl/in_filter.sv ----
// three-flop input synchroniser, output follows when last two agree
`timescale 1ns/1ns
module in_filter #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } filt_t;
   filt_t s;
   filt_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.q = (s.s2 & s.s3) | (s.q & (s.s2 ^ s.s3));
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= {INIT, INIT, INIT, INIT};
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule // in_filter

// ---- rtl/i2c_switch_dev.sv ----
// switch end: address match, control byte, deferred channel select, interrupt merge
`timescale 1ns/1ns
module i2c_switch_dev
   import i2c_switch_pkg::*;
#(
   parameter logic [4:0] ADDR_FIXED = ADDR_FIXED_DEFAULT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   i2c_link_if.dev link,
   input wire logic addr_select_lo,
   input wire logic addr_select_hi,
   input wire logic chan0_irq_in_n,
   input wire logic chan1_irq_in_n,
   input wire logic chan2_irq_in_n,
   input wire logic chan3_irq_in_n,
   output logic [NUM_CHAN-1:0] chan_enable,
   output logic irq_out_oe
);
   // link-side byte engine, cleared by reset and by every start or stop
   typedef struct packed {
      dev_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] shr;
      logic hit;
      logic [7:0] rd_sh;
   } link_st_t;

   // control register survives frames, only the reset input clears it
   typedef struct packed {
      logic [3:0] ctrl;
   } ctl_st_t;

   // system-clock side: bus condition detect and channel switch
   typedef struct packed {
      logic sda_prev;
      logic link_clear;
      logic [3:0] ctrl_s1;
      logic [3:0] ctrl_s2;
      logic [3:0] chan_en;
      logic irq_oe;
   } sys_st_t;

   localparam link_st_t LINK_RESET = '{PH_ADDR, 4'h0, 8'h00, 1'b0, 8'h00};
   localparam ctl_st_t CTL_RESET = '{CTRL_RESET};
   localparam sys_st_t SYS_RESET = '{1'b1, 1'b1, CTRL_RESET, CTRL_RESET, CHAN_RESET, 1'b0};

   link_st_t l;
   link_st_t next_l;
   ctl_st_t c;
   ctl_st_t next_c;
   sys_st_t s;
   sys_st_t next_s;
   logic drv_oe;
   logic link_rst_n;
   logic [3:0] irq_pins_n;
   logic [5:0] link_pins;
   logic [5:0] sys_pins;
   logic [7:0] read_byte;
   logic scl_f;
   logic sda_f;
   logic start_seen;
   logic stop_seen;

   assign irq_pins_n = {chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n};

   // straps and interrupt pins seen on the link clock
   in_filter #(
      .W(6),
      .INIT(6'h3f)
   ) u_link_pins (
      .clk(link.scl),
      .rstn(rstn),
      .ce(1'b1),
      .d({addr_select_hi, addr_select_lo, irq_pins_n}),
      .q(link_pins)
   );

   // bus lines and interrupt pins seen on the system clock
   in_filter #(
      .W(6),
      .INIT(6'h3f)
   ) u_sys_pins (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .d({link.scl, link.sda, irq_pins_n}),
      .q(sys_pins)
   );

   assign scl_f = sys_pins[5];
   assign sda_f = sys_pins[4];
   assign link_rst_n = rstn && !s.link_clear;

   // pins read back inverted, so a low pin reads as 1
   assign read_byte = {~link_pins[3:0], c.ctrl};

   always_comb begin
      next_l = l;
      next_c = c;
      if (l.cnt != BIT_ACK) begin
         next_l.shr = {l.shr[6:0], link.sda};
         next_l.cnt = l.cnt + 4'h1;
         if (l.cnt == BIT_LAST) begin
            next_l.hit = (l.shr[6:0] == {ADDR_FIXED, link_pins[5:4]});
         end
         if (l.ph == PH_READ) begin
            next_l.rd_sh = {l.rd_sh[6:0], 1'b0};
         end
      end else begin
         next_l.cnt = 4'h0;
         case (l.ph)
            PH_ADDR: begin
               if (!l.hit) begin
                  next_l.ph = PH_IGNORE;
               end else if (l.shr[0]) begin
                  next_l.ph = PH_READ;
                  next_l.rd_sh = read_byte;
               end else begin
                  next_l.ph = PH_WRITE;
               end
            end
            PH_WRITE: begin
               next_c.ctrl = l.shr[3:0];
            end
            PH_READ: begin
               if (link.sda) begin
                  next_l.ph = PH_IGNORE;
               end else begin
                  next_l.rd_sh = read_byte;
               end
            end
            default: begin
               next_l.ph = PH_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge link.scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         l <= LINK_RESET;
      end else begin
         l <= next_l;
      end
   end

   always_ff @(posedge link.scl or negedge rstn) begin
      if (!rstn) begin
         c <= CTL_RESET;
      end else begin
         c <= next_c;
      end
   end

   // data and acknowledge change only while the clock is low
   always_ff @(negedge link.scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         drv_oe <= 1'b0;
      end else if (l.cnt == BIT_ACK) begin
         drv_oe <= (l.ph == PH_ADDR && l.hit) || l.ph == PH_WRITE;
      end else begin
         drv_oe <= l.ph == PH_READ && !l.rd_sh[7];
      end
   end

   assign link.sda_dev_oe = drv_oe;

   always_comb begin
      next_s = s;
      start_seen = scl_f && s.sda_prev && !sda_f;
      stop_seen = scl_f && !s.sda_prev && sda_f;
      next_s.sda_prev = sda_f;
      // link engine released once the clock falls after a start
      next_s.link_clear = start_seen || stop_seen || (s.link_clear && scl_f);
      next_s.ctrl_s1 = c.ctrl;
      next_s.ctrl_s2 = s.ctrl_s1;
      // all chosen channels together
      // every stop reloads; with no write since the last stop nothing moves,
      // and any number of bytes in one frame still leaves the last one
      if (stop_seen) begin
         next_s.chan_en = s.ctrl_s2;
      end
      next_s.irq_oe = sys_pins[3:0] != IRQ_PINS_IDLE;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= SYS_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign chan_enable = s.chan_en;
   assign irq_out_oe = s.irq_oe;
endmodule // i2c_switch_dev

// ---- rtl/i2c_switch_host.sv ----
// bus master end: one address byte then, if acknowledged, one data byte per request
`timescale 1ns/1ns
module i2c_switch_host
   import i2c_switch_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   i2c_link_if.host link,
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic [6:0] req_addr,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic done,
   output logic ack_err,
   output logic [7:0] rd_data
);
   localparam logic [15:0] QMAX = 16'(QUARTER - 1);

   typedef struct packed {
      host_state_t st;
      logic [1:0] q;
      logic [15:0] tcnt;
      logic [3:0] bitn;
      logic byte1;
      logic rd;
      logic [7:0] txs;
      logic [7:0] dat;
      logic [7:0] shr;
      logic scl;
      logic sda_oe;
      logic ready;
      logic done;
      logic ack_err;
      logic [7:0] rd_data;
   } host_st_t;

   localparam host_st_t HOST_RESET = '{HS_IDLE, 2'h0, 16'h0000, 4'h0, 1'b0, 1'b0, 8'h00,
      8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};

   host_st_t h;
   host_st_t next_h;
   logic sda_f;
   logic tick;
   logic xmit;

   in_filter #(
      .W(1),
      .INIT(1'b1)
   ) u_sda (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .d(link.sda),
      .q(sda_f)
   );

   always_comb begin
      next_h = h;
      next_h.done = 1'b0;
      tick = h.tcnt == QMAX;
      xmit = !h.byte1 || !h.rd;
      next_h.tcnt = tick ? 16'h0000 : h.tcnt + 16'h0001;
      if (tick) begin
         next_h.q = h.q + 2'h1;
      end
      case (h.st)
         HS_IDLE: begin
            next_h.tcnt = 16'h0000;
            next_h.q = 2'h0;
            if (req_valid) begin
               next_h.st = HS_START;
               next_h.ready = 1'b0;
               next_h.ack_err = 1'b0;
               next_h.rd = req_read;
               next_h.txs = {req_addr, req_read};
               next_h.dat = req_data;
               next_h.byte1 = 1'b0;
               next_h.bitn = 4'h0;
            end
         end
         HS_START: begin
            if (tick && h.q == 2'h0) begin
               next_h.sda_oe = 1'b1;
            end else if (tick) begin
               next_h.scl = 1'b0;
               next_h.st = HS_BIT;
               next_h.q = 2'h0;
            end
         end
         HS_BIT: begin
            if (tick) begin
               case (h.q)
                  2'h0: next_h.sda_oe = xmit && h.bitn != BIT_ACK && !h.txs[7];
                  2'h1: next_h.scl = 1'b1;
                  2'h2: begin
                     if (h.bitn != BIT_ACK) begin
                        next_h.shr = {h.shr[6:0], sda_f};
                     end else if (xmit && sda_f) begin
                        next_h.ack_err = 1'b1;
                     end
                  end
                  default: begin
                     next_h.scl = 1'b0;
                     if (h.bitn != BIT_ACK) begin
                        next_h.bitn = h.bitn + 4'h1;
                        next_h.txs = {h.txs[6:0], 1'b0};
                     end else if (h.byte1 || h.ack_err) begin
                        next_h.st = HS_STOP;
                        if (h.rd) begin
                           next_h.rd_data = h.shr;
                        end
                     end else begin
                        next_h.byte1 = 1'b1;
                        next_h.bitn = 4'h0;
                        next_h.txs = h.dat;
                     end
                  end
               endcase
            end
         end
         HS_STOP: begin
            if (tick) begin
               case (h.q)
                  2'h0: next_h.sda_oe = 1'b1;
                  2'h1: next_h.scl = 1'b1;
                  2'h2: next_h.sda_oe = 1'b0;
                  default: begin
                     next_h.st = HS_IDLE;
                     next_h.done = 1'b1;
                     next_h.ready = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            next_h = HOST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         h <= HOST_RESET;
      end else if (ce) begin
         h <= next_h;
      end
   end

   assign link.scl = h.scl;
   assign link.sda_host_oe = h.sda_oe;
   assign req_ready = h.ready;
   assign done = h.done;
   assign ack_err = h.ack_err;
   assign rd_data = h.rd_data;
endmodule // i2c_switch_host

// ---- test/i2c_switch_checker.sv ----
// concurrent checks on the two-wire link between master end and switch end
`timescale 1ns/1ns
module i2c_switch_checker #(
   parameter int QUARTER = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic sda
);
   localparam int SPAN = 3 * QUARTER;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   dev_no_start_a: assert property ($fell(sda) && scl |-> !sda_dev_oe)
      else $error("switch end made a start condition");
   dev_change_a: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("switch end moved sda while scl high");
   scl_high_a: assert property ($rose(scl) |=> scl [*7])
      else $error("scl high phase too short");
   scl_low_a: assert property ($fell(scl) |=> !scl [*7])
      else $error("scl low phase too short");
   start_low_a: assert property ($fell(sda) && scl |-> ##[1:SPAN] !scl)
      else $error("no clocking after start");
   stop_idle_a: assert property ($rose(sda) && scl |=> (scl && sda) [*7])
      else $error("link not idle after stop");
   reset_idle_a: assert property ($rose(rstn) |-> scl && !sda_host_oe && !sda_dev_oe)
      else $error("link not released after reset");
   ack_span_a: assert property ($rose(sda_dev_oe) |-> !scl ##[1:SPAN] scl)
      else $error("switch drive not clocked out");
   cover property ($rose(sda_dev_oe));
   cover property ($fell(sda) && scl);
   cover property ($rose(sda) && scl);
endmodule // i2c_switch_checker

// ---- test/tb_i2c_switch_ctrl_irq.sv ----
// bench joining master end and switch end, plus a hand-driven second link
`timescale 1ns/1ns
module tb_i2c_switch_ctrl_irq;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic [6:0] req_addr = 7'h00;
   logic [7:0] req_data = 8'h00;
   logic req_ready, done, ack_err, irq_out_oe;
   logic [7:0] rd_data;
   logic [3:0] chan_enable, chan_enable_b;
   logic [3:0] irq_n = 4'hf;
   logic strap_lo = 1'b0;
   logic strap_hi = 1'b1;
   int fail_count = 0;
   int comparisons = 0;
   always #2 clk = ~clk;
   i2c_link_if link();
   i2c_link_if link_b();
   i2c_switch_host #(.QUARTER(8)) i2c_switch_host_i (.clk(clk), .rstn(rstn), .ce(1'b1),
      .link(link.host), .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr),
      .req_data(req_data), .req_ready(req_ready), .done(done), .ack_err(ack_err),
      .rd_data(rd_data));
   i2c_switch_dev i2c_switch_dev_i (.clk(clk), .rstn(rstn), .ce(1'b1), .link(link.dev),
      .addr_select_lo(strap_lo), .addr_select_hi(strap_hi), .chan0_irq_in_n(irq_n[0]),
      .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]),
      .chan_enable(chan_enable), .irq_out_oe(irq_out_oe));
   // second switch end on a link driven by hand
   i2c_switch_dev i2c_switch_dev_b_i (.clk(clk), .rstn(rstn), .ce(1'b1), .link(link_b.dev),
      .addr_select_lo(strap_lo), .addr_select_hi(strap_hi), .chan0_irq_in_n(irq_n[0]),
      .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]),
      .chan_enable(chan_enable_b), .irq_out_oe());
   i2c_switch_checker #(.QUARTER(8)) i2c_switch_checker_i (.clk(clk), .rstn(rstn),
      .scl(link.scl), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
      .sda(link.sda));

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
      logic [3:0] old;
      int n;
      old = chan_enable;
      req_read = rd;
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      tick(1);
      req_valid = 1'b0;
      for (n = 0; n < 2000 && done !== 1'b1; n++) begin
         if (n == 400)
            chk(8'(chan_enable), 8'(old));
         tick(1);
      end
      if (n == 2000) begin
         fail_count++;
         end_sim();
      end
      chk({6'h00, link.scl, link.sda}, 8'h03);
      chk(8'(req_ready), 8'h01);
   endtask

   task bb(input logic s, input logic d);
      tick(8);
      link_b.scl = s;
      link_b.sda_host_oe = !d;
   endtask

   task bb_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bb(1'b0, b[i]);
         bb(1'b1, b[i]);
         bb(1'b0, b[i]);
      end
      // released for the acknowledge, looked at while scl is high
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      chk(8'(link_b.sda), 8'h00);
      bb(1'b0, 1'b1);
   endtask

   initial begin
      link_b.scl = 1'b1;
      link_b.sda_host_oe = 1'b0;
      tick(12);
      rstn = 1'b1;
      chk(8'(chan_enable), 8'h00);
      // switch address: fixed bits 0a, strap hi 1, strap lo 0
      xfer(1'b1, 7'h2a, 8'h00);
      chk(rd_data, 8'h00);
      xfer(1'b0, 7'h2a, 8'hf5);
      tick(10);
      chk(8'(chan_enable), 8'h05);
      xfer(1'b1, 7'h2a, 8'h00);
      chk(rd_data, 8'h05);
      irq_n = 4'h9;
      tick(10);
      chk(8'(irq_out_oe), 8'h01);
      xfer(1'b1, 7'h2a, 8'h00);
      chk(rd_data, 8'h65);
      irq_n = 4'hf;
      tick(10);
      chk(8'(irq_out_oe), 8'h00);
      xfer(1'b1, 7'h2a, 8'h00);
      chk(rd_data, 8'h05);
      for (int i = 0; i < 4; i++) begin
         irq_n = ~4'(1 << i);
         xfer(1'b0, 7'h2a, 8'(1 << i));
         tick(10);
         chk(8'(chan_enable), 8'(1 << i));
         xfer(1'b1, 7'h2a, 8'h00);
         chk(rd_data, 8'(8'h11 << i));
      end
      irq_n = 4'hf;
      // foreign address is not acknowledged and changes nothing
      xfer(1'b0, 7'h2b, 8'h0f);
      chk(8'(ack_err), 8'h01);
      tick(10);
      chk(8'(chan_enable), 8'h08);
      rstn = 1'b0;
      tick(3);
      chk(8'(chan_enable), 8'h00);
      rstn = 1'b1;
      xfer(1'b1, 7'h2a, 8'h00);
      chk(rd_data, 8'h00);
      chk(8'(ack_err), 8'h00);
      // two data bytes in one write frame on the second link
      bb(1'b1, 1'b1);
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
      bb_byte(8'h54);
      bb_byte(8'h03);
      bb_byte(8'h0c);
      bb(1'b0, 1'b0);
      bb(1'b1, 1'b0);
      bb(1'b1, 1'b1);
      tick(10);
      chk(8'(chan_enable_b), 8'h0c);
      end_sim();
   end
endmodule // tb_i2c_switch_ctrl_irq
